// >>> verification/stt_assertions.sv
// Port checker for the tick timer, bound to its top
`timescale 1ns/1ps
module stt_checker (
	// Clock and reset
	input logic ref_clk,
	input logic rst_n,
	// Bus
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	// Core side
	input logic tickRequest,
	input logic [7:0] supervisorCallPriority,
	input logic [7:0] pendableServicePriority,
	input logic [7:0] tickExceptionPriority
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Word index and finished accesses
	wire [5:0] wa = wb_adr_i[7:2];
	wire rd = wb_ack_o && !wb_we_i;
	wire wr = wb_ack_o && wb_we_i;
	// Interrupt enable as last written; lane 0 only
	logic intSh_reg;
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n) intSh_reg <= 1'h0;
		else if (wr && wa == 6'h00 && wb_sel_i[0]) intSh_reg <= wb_dat_i[1];
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_hole_zero: assert property (rd && wa > 6'h07 |-> wb_dat_o == 32'h0)
		else $error("hole not zero");
	a_ctrl_resv: assert property (rd && wa == 6'h00 |-> wb_dat_o[31:17] == 15'h0
		&& wb_dat_o[15:3] == 13'h0) else $error("ctrl reserved set");
	a_prio_resv: assert property (rd && wa == 6'h03 |-> wb_dat_o[23:0] == 24'h0)
		else $error("prio2 reserved set");
	a_svc_field: assert property (wr && wa == 6'h03 && wb_sel_i[3]
		|-> ##2 supervisorCallPriority == $past(wb_dat_i[31:24], 2)) else $error("svc");
	a_tick_field: assert property (wr && wa == 6'h04 && wb_sel_i[3]
		|-> ##2 tickExceptionPriority == $past(wb_dat_i[31:24], 2)) else $error("tick");
	a_pend_field: assert property (wr && wa == 6'h04 && wb_sel_i[2]
		|-> ##2 pendableServicePriority == $past(wb_dat_i[23:16], 2)) else $error("pend");
	a_req_gated: assert property (tickRequest |-> intSh_reg || $past(intSh_reg))
		else $error("request while off");
	a_req_pulse: assert property (tickRequest |=> !tickRequest) else $error("req held");
endmodule

bind stt_system_tick_timer stt_checker u_stt_checker (.ref_clk, .rst_n, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.tickRequest, .supervisorCallPriority, .pendableServicePriority,
	.tickExceptionPriority);

// >>> verification/stt_core_model.sv
// Core-side model: counts tick requests and their spacing
`timescale 1ns/1ps
module stt_core_model (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Request from the timer
	input wire tickRequest,
	// Observed counts
	output int pulses,
	output int gap
);
	// Cycles since the last request
	int cnt;
	// Spacing is measured edge to edge, so one extra cycle shows at once
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulses <= 0;
			gap <= 0;
			cnt <= 0;
		end else if (tickRequest === 1'h1) begin
			pulses <= pulses + 1;
			gap <= cnt + 1;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> verification/stt_system_tick_timer_tb.sv
// Self-checking bench for the system tick timer
`timescale 1ns/1ps
module stt_system_tick_timer_tb;
	// Clock, reset and bus drive
	logic ref_clk = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, rdat, q, pv;
	// Design outputs
	wire [31:0] wb_dat_o;
	wire wb_ack_o, tickRequest, irq;
	wire [7:0] supervisorCallPriority, pendableServicePriority, tickExceptionPriority;
	int fails = 0, checks = 0, seed = 32'h4118, pulses, gap, r, p0;
	always #5 ref_clk = ~ref_clk;
	stt_system_tick_timer u_stt_system_tick_timer (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tickRequest,
		.supervisorCallPriority, .pendableServicePriority, .tickExceptionPriority, .irq);
	stt_core_model u_stt_core_model (.ref_clk, .rst_n, .tickRequest, .pulses, .gap);
	// One classic cycle; waits for ack under a bound
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 20);
		if (n >= 20) fails++;
		rdat = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask
	// Compare one result with the model
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(rdat, e);
	endtask
	task close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'h1;
		// Unmapped space reads zero, writes vanish
		bus(1'h1, 8'h24, 32'hFFFFFFFF);
		rd(8'h24, 32'h0);
		// Priority fields with random contents
		pv = $random(seed);
		bus(1'h1, 8'h0C, pv);
		rd(8'h0C, pv & 32'hFF000000);
		bus(1'h1, 8'h10, pv);
		rd(8'h10, pv & 32'hFFFF0000);
		chk({supervisorCallPriority, tickExceptionPriority, pendableServicePriority},
			{8'h00, pv[31:24], pv[31:24], pv[23:16]});
		// Direct source, then divided by eight
		r = ($random(seed) & 7) + 1;
		bus(1'h1, 8'h04, r);
		bus(1'h1, 8'h00, 32'h7);
		repeat (3 * (r + 1) + 4) @(posedge ref_clk);
		chk(gap, r + 1);
		bus(1'h1, 8'h00, 32'h3);
		repeat (24 * (r + 1) + 20) @(posedge ref_clk);
		chk(gap, 8 * (r + 1));
		// Interrupt enable off: flag only
		bus(1'h1, 8'h00, 32'h5);
		bus(1'h0, 8'h00, 32'h0);
		p0 = pulses;
		repeat (3 * (r + 1) + 4) @(posedge ref_clk);
		chk(pulses, p0);
		bus(1'h1, 8'h00, 32'h0);
		rd(8'h00, 32'h00010000);
		rd(8'h00, 32'h0);
		// Stopped counter holds its value
		bus(1'h0, 8'h08, 32'h0);
		q = rdat;
		repeat (10) @(posedge ref_clk);
		rd(8'h08, q);
		// Interrupt line: raise, mask, clear
		bus(1'h1, 8'h1C, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 32'h1);
		bus(1'h1, 8'h1C, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk(irq, 32'h0);
		bus(1'h1, 8'h18, 32'h1);
		rd(8'h14, 32'h0);
		close_out;
	end
	// Watchdog well beyond the longest sequence
	initial begin
		#500000;
		fails++;
		close_out;
	end
endmodule

// >>> verilog/stt_map.vh
// Register map, field positions, reset values and timing for the tick timer
`ifndef STT_MAP_VH
`define STT_MAP_VH

// Register word offsets, byte address bits [7:2]
`define STT_ADDR_CONTROL 6'h00
`define STT_ADDR_RELOAD 6'h01
`define STT_ADDR_CURRENT 6'h02
`define STT_ADDR_PRIO2 6'h03
`define STT_ADDR_PRIO3 6'h04
`define STT_ADDR_IRQ_STAT 6'h05
`define STT_ADDR_IRQ_CLR 6'h06
`define STT_ADDR_IRQ_EN 6'h07

// Control and status fields
`define STT_BIT_ENABLE 0
`define STT_BIT_TICK_IE 1
`define STT_BIT_CLKSRC 2
`define STT_BIT_FLAG 16

// Priority register field masks
`define STT_PRIO2_MASK 32'hFF000000
`define STT_PRIO3_MASK 32'hFFFF0000
`define STT_PRIO_SVC_MSB 31
`define STT_PRIO_SVC_LSB 24
`define STT_PRIO_TICK_MSB 31
`define STT_PRIO_TICK_LSB 24
`define STT_PRIO_PEND_MSB 23
`define STT_PRIO_PEND_LSB 16

// Counter width and values
`define STT_CNT_W 24
`define STT_CNT_ZERO 24'h000000
`define STT_CNT_ONE 24'h000001
`define STT_CNT_MASK 32'h00FFFFFF

// Interrupt status bit for the reached-zero event
`define STT_IRQ_ZERO 0

// Divide-by-8 prescaler
`define STT_DIV_W 3
`define STT_DIV_ZERO 3'h0
`define STT_DIV_ONE 3'h1
`define STT_DIV_LAST 3'h7

// Common reset values
`define STT_WORD_ZERO 32'h00000000

`endif

// >>> verilog/stt_system_tick_timer.v
// System tick timer with handler priority fields and a Wishbone slave
`timescale 1ns/1ps
`include "stt_map.vh"

// Operation
// - Flag reads 1 after zero, read clears
// - Source bit 0 divides by 8, 1 direct
// - Exception request only while interrupt enable set
// - Stopped when disabled; enabling loads reload first
// - Zero sets flag and optional request together
// - Reload after zero, keep counting periodically
// - Tick priority in top byte, register three
// - Pendable service priority bits 23:16, register three
// - Supervisor priority top byte, register two
module stt_system_tick_timer (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Exception request to the core
	output reg tickRequest,
	// Handler priorities to the core
	output reg [7:0] supervisorCallPriority,
	output reg [7:0] pendableServicePriority,
	output reg [7:0] tickExceptionPriority,
	// Interrupt line
	output reg irq
);

	// Byte-lane merge of a write into an existing word
	function [31:0] laneMerge;
		input [31:0] oldWord;
		input [31:0] newWord;
		input [3:0] sel;
		integer i;
		begin
			laneMerge = oldWord;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					laneMerge[i*8 +: 8] = newWord[i*8 +: 8];
				end
			end
		end
	endfunction

	// Write mask with byte enables: ones where a lane is written
	function [31:0] laneMask;
		input [3:0] sel;
		integer i;
		begin
			laneMask = `STT_WORD_ZERO;
			for (i = 0; i < 4; i = i + 1) begin
				laneMask[i*8 +: 8] = {8{sel[i]}};
			end
		end
	endfunction

	// Bus decode
	// Address bits 1:0 are ignored; reads are whole words, writes pick byte lanes with wb_sel_i
	wire busReq; // Live request on the bus
	wire [5:0] wordAddr; // Word index of the access
	wire readTake; // Read answered at this edge
	wire writeTake; // Write committed at this edge
	assign busReq = wb_cyc_i & wb_stb_i;
	assign wordAddr = wb_adr_i[7:2];
	// A read acts at the request edge and a write at the ack edge, so a
	// read side effect and a register update never fall on one access edge
	assign readTake = busReq & ~wb_we_i & ~wb_ack_o;
	assign writeTake = busReq & wb_we_i & wb_ack_o;

	// Software-visible state
	reg enableBit_reg; // Counter run enable
	reg tickIntEnable_reg; // Exception request enable
	reg clockSourceSelect_reg; // 1 = main clock, 0 = divided by 8
	reg reachedZeroFlag_reg; // Sticky, cleared by reading control
	reg [`STT_CNT_W-1:0] reloadValue_reg; // Programmed reload
	reg [`STT_CNT_W-1:0] currentCount_reg; // Live down-counter
	reg [31:0] prio2_reg; // Supervisor call priority word
	reg [31:0] prio3_reg; // Pendable service and tick priority word
	reg irqStatus_reg; // Sticky interrupt status
	reg irqEnable_reg; // Interrupt enable

	// Reload word after a byte-lane write; its top byte is dropped on purpose
	wire [31:0] reloadMerged;
	assign reloadMerged = laneMerge({8'h00, reloadValue_reg}, wb_dat_i, wb_sel_i);

	// Counter control
	reg enableDly_reg; // Enable one cycle ago, for load on rise
	wire enableRise; // First cycle of a run
	wire tick; // Selected clock source tick
	wire zeroHit; // Counter steps from one to zero
	assign enableRise = enableBit_reg & ~enableDly_reg;
	// The event is the step from one to zero, not sitting at zero, so a
	// reload value of zero never raises an event
	assign zeroHit = enableBit_reg & ~enableRise & tick &
		(currentCount_reg == `STT_CNT_ONE);

	// Clock source selection and division
	// Divider is held while stopped so every run starts from a clean phase
	stt_tick_gen tickGen (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.runEn(enableBit_reg),
		.clockSourceSelect(clockSourceSelect_reg),
		.tickPulse_reg(tick)
	);

	// Readback mux of the addressed register
	reg [31:0] readData_next;
	always @* begin
		readData_next = `STT_WORD_ZERO;
		case (wordAddr)
			`STT_ADDR_CONTROL: begin
				// Reserved bits stay zero
				readData_next[`STT_BIT_ENABLE] = enableBit_reg;
				readData_next[`STT_BIT_TICK_IE] = tickIntEnable_reg;
				readData_next[`STT_BIT_CLKSRC] = clockSourceSelect_reg;
				readData_next[`STT_BIT_FLAG] = reachedZeroFlag_reg;
			end
			`STT_ADDR_RELOAD: begin
				readData_next[`STT_CNT_W-1:0] = reloadValue_reg;
			end
			// Current value is read live; a read never disturbs the count
			`STT_ADDR_CURRENT: begin
				readData_next[`STT_CNT_W-1:0] = currentCount_reg;
			end
			`STT_ADDR_PRIO2: begin
				readData_next = prio2_reg & `STT_PRIO2_MASK;
			end
			`STT_ADDR_PRIO3: begin
				readData_next = prio3_reg & `STT_PRIO3_MASK;
			end
			`STT_ADDR_IRQ_STAT: begin
				readData_next[`STT_IRQ_ZERO] = irqStatus_reg;
			end
			`STT_ADDR_IRQ_EN: begin
				readData_next[`STT_IRQ_ZERO] = irqEnable_reg;
			end
			default: begin
				// Unmapped and write-only words read as zero
				readData_next = `STT_WORD_ZERO;
			end
		endcase
	end

	// Bus answer: ack one cycle after the request, dropped the next
	// Ack is low again before a master can raise its next request
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `STT_WORD_ZERO;
		end else begin
			wb_ack_o <= busReq & ~wb_ack_o;
			if (readTake) begin
				// Data captured with ack so it is stable when sampled
				wb_dat_o <= readData_next;
			end
		end
	end

	// Control bits and reload value, written on the ack edge
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enableBit_reg <= 1'b0;
			tickIntEnable_reg <= 1'b0;
			clockSourceSelect_reg <= 1'b0;
			reloadValue_reg <= `STT_CNT_ZERO;
		end else if (writeTake) begin
			if (wordAddr == `STT_ADDR_CONTROL && wb_sel_i[0]) begin
				// All control bits live in the low byte
				// Lane 0 off leaves every control bit as it was
				enableBit_reg <= wb_dat_i[`STT_BIT_ENABLE];
				tickIntEnable_reg <= wb_dat_i[`STT_BIT_TICK_IE];
				clockSourceSelect_reg <= wb_dat_i[`STT_BIT_CLKSRC];
			end
			if (wordAddr == `STT_ADDR_RELOAD) begin
				reloadValue_reg <= reloadMerged[`STT_CNT_W-1:0];
			end
		end
	end

	// Priority words, only the documented fields are stored
	// Reserved bits are masked on entry as well as on readback
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prio2_reg <= `STT_WORD_ZERO;
			prio3_reg <= `STT_WORD_ZERO;
		end else if (writeTake) begin
			if (wordAddr == `STT_ADDR_PRIO2) begin
				prio2_reg <= laneMerge(prio2_reg, wb_dat_i, wb_sel_i) &
					`STT_PRIO2_MASK;
			end
			if (wordAddr == `STT_ADDR_PRIO3) begin
				prio3_reg <= laneMerge(prio3_reg, wb_dat_i, wb_sel_i) &
					`STT_PRIO3_MASK;
			end
		end
	end

	// Priority fields driven to the core from flip-flops
	// The core sees a new priority one cycle after the write commits
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			supervisorCallPriority <= 8'h00;
			pendableServicePriority <= 8'h00;
			tickExceptionPriority <= 8'h00;
		end else begin
			supervisorCallPriority <= prio2_reg[`STT_PRIO_SVC_MSB:`STT_PRIO_SVC_LSB];
			pendableServicePriority <= prio3_reg[`STT_PRIO_PEND_MSB:`STT_PRIO_PEND_LSB];
			tickExceptionPriority <= prio3_reg[`STT_PRIO_TICK_MSB:`STT_PRIO_TICK_LSB];
		end
	end

	// Down-counter: load on enable, decrement per tick, reload after zero
	// Limitation: a reload written mid-run only takes effect at the next
	// wrap, the running period is not cut short
	// Disabling freezes the count rather than clearing it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enableDly_reg <= 1'b0;
			currentCount_reg <= `STT_CNT_ZERO;
		end else begin
			enableDly_reg <= enableBit_reg;
			if (!enableBit_reg) begin
				// Stopped: count holds its value
				currentCount_reg <= currentCount_reg;
			end else if (enableRise) begin
				// First cycle of a run takes the reload value
				currentCount_reg <= reloadValue_reg;
			end else if (tick) begin
				if (currentCount_reg == `STT_CNT_ZERO) begin
					// Period restarts on the tick after zero
					currentCount_reg <= reloadValue_reg;
				end else begin
					currentCount_reg <= currentCount_reg - `STT_CNT_ONE;
				end
			end
		end
	end

	// Reached-zero flag: set wins over the clear by a read
	// Hazard: a read on the same edge as the event must not lose the
	// event, so the set is tested first
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reachedZeroFlag_reg <= 1'b0;
		end else if (zeroHit) begin
			reachedZeroFlag_reg <= 1'b1;
		end else if (readTake && wordAddr == `STT_ADDR_CONTROL) begin
			// The read that returns the flag also clears it
			reachedZeroFlag_reg <= 1'b0;
		end
	end

	// Exception request: one-cycle pulse, gated by interrupt enable
	// A pulse, not a level: the core keeps its own pending state
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickRequest <= 1'b0;
		end else begin
			tickRequest <= zeroHit & tickIntEnable_reg;
		end
	end

	// Interrupt status, clear and enable registers
	// Clear needs both the data bit and lane 0, a partial write keeps it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStatus_reg <= 1'b0;
			irqEnable_reg <= 1'b0;
		end else begin
			if (zeroHit) begin
				// Event beats a clear in the same cycle
				irqStatus_reg <= 1'b1;
			end else if (writeTake && wordAddr == `STT_ADDR_IRQ_CLR &&
				(wb_dat_i[`STT_IRQ_ZERO] & wb_sel_i[0])) begin
				irqStatus_reg <= 1'b0;
			end
			if (writeTake && wordAddr == `STT_ADDR_IRQ_EN && wb_sel_i[0]) begin
				irqEnable_reg <= wb_dat_i[`STT_IRQ_ZERO];
			end
		end
	end

	// Level interrupt from a flip-flop; one cycle behind the status
	// Trade-off: one cycle of lag buys an output straight from a register
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irqStatus_reg & irqEnable_reg;
		end
	end

endmodule

// >>> verilog/stt_tick_gen.v
// Tick source: main clock direct or main clock divided by eight
`timescale 1ns/1ps
`include "stt_map.vh"

module stt_tick_gen (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// Control
	input wire runEn,
	input wire clockSourceSelect,
	// Tick out
	output reg tickPulse_reg
);

	// Prescaler position within the eight-cycle period
	reg [`STT_DIV_W-1:0] preCount_reg;

	// Prescaler restarts whenever the counter is stopped, so the first
	// divided tick comes a full period after enabling
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			preCount_reg <= `STT_DIV_ZERO;
			tickPulse_reg <= 1'b0;
		end else if (!runEn) begin
			// Stopped: no ticks at all
			preCount_reg <= `STT_DIV_ZERO;
			tickPulse_reg <= 1'b0;
		end else begin
			preCount_reg <= preCount_reg + `STT_DIV_ONE;
			// One tick per clock, or one per eight clocks
			tickPulse_reg <= clockSourceSelect | (preCount_reg == `STT_DIV_LAST);
		end
	end

endmodule
